// ===== rtl/tcm_pkg.sv
`default_nettype none

package tcm_pkg;

  // ==========================================================================
  // memory geometry
  localparam int CM_WORDS = 8192;
  localparam int CM_WIDTH = 16;
  localparam int IDX_W = 13;
  localparam int ADDR_W = 15;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================================
  // address map: bit 14 high selects connection memory space
  localparam int ADDR_MEM_BIT = 14;
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;

  // ==========================================================================
  // control_reg layout, mem_select_b2..b0 in bits 2:0
  localparam int CTL_SEL_LO = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [2:0] SEL_LOCAL = 3'h0;
  localparam logic [2:0] SEL_BACKPLANE = 3'h1;

  // status layout
  localparam int ST_ILLEGAL_BIT = 0;
  localparam int ST_READY_BIT = 1;

  // ==========================================================================
  // connection word layout
  localparam int CW_SRC_BIT = 15;
  localparam int CW_MSG_BIT = 14;
  localparam int CW_HIZ_BIT = 13;
  localparam int CW_STREAM_HI = 12;
  localparam int CW_STREAM_LO = 8;
  localparam int CW_STREAM32_LO = 9;
  localparam int CW_CHAN_HI = 7;
  localparam int CW_CHAN32_HI = 8;

  // highest legal channel per source rate
  localparam logic [8:0] CHAN_MAX_2M = 9'h01F;
  localparam logic [8:0] CHAN_MAX_4M = 9'h03F;
  localparam logic [8:0] CHAN_MAX_8M = 9'h07F;
  localparam logic [8:0] CHAN_MAX_16M = 9'h0FF;
  localparam logic [8:0] CHAN_MAX_32M = 9'h1FF;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {RATE_2M, RATE_4M, RATE_8M, RATE_16M, RATE_32M} tcm_rate_t;
  typedef enum logic {PORT_LOCAL, PORT_BACKPLANE} tcm_port_t;

  typedef struct packed {
    tcm_port_t port;
    logic [12:0] slot;
    tcm_rate_t rate;
  } tcm_req_t;

  typedef struct packed {
    tcm_port_t port;
    logic [12:0] slot;
    logic src_local;
    logic msg_mode;
    logic hiz;
    logic [4:0] stream;
    logic [8:0] chan;
    logic [7:0] msg;
    logic illegal;
  } tcm_cmd_t;

endpackage

`default_nettype wire

// ===== rtl/tcm_conn_mem.sv
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// fifo with registered head and registered ready
module tcm_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // fill side
  input wire logic s_valid_i,
  input wire logic [WIDTH-1:0] s_data_i,
  output logic s_ready_o,
  // drain side
  output logic m_valid_o,
  output logic [WIDTH-1:0] m_data_o,
  input wire logic m_ready_i
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
    logic in_rdy;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } tcm_fifo_state_t;

  tcm_fifo_state_t cur;
  tcm_fifo_state_t next_cur;

  always_comb begin
    logic push;
    logic out_free;
    logic to_store;
    push = 1'b0;
    out_free = 1'b0;
    to_store = 1'b0;
    next_cur = cur;
    if (ce_i) begin
      push = s_valid_i && cur.in_rdy;
      out_free = !cur.out_valid || m_ready_i;
      to_store = push;
      if (out_free) begin
        // storage drains first so word order is kept
        if (cur.count != '0) begin
          next_cur.out_data = cur.mem[cur.rp];
          next_cur.out_valid = 1'b1;
          next_cur.rp = PW'(cur.rp + 1'b1);
          next_cur.count = cur.count - 1'b1;
        end else if (push) begin
          next_cur.out_data = s_data_i;
          next_cur.out_valid = 1'b1;
          to_store = 1'b0;
        end else begin
          next_cur.out_valid = 1'b0;
        end
      end
      if (to_store) begin
        next_cur.mem[cur.wp] = s_data_i;
        next_cur.wp = PW'(cur.wp + 1'b1);
        next_cur.count = next_cur.count + 1'b1;
      end
      // ready from the next count alone keeps it a flop, at the cost of one bubble
      next_cur.in_rdy = next_cur.count < (PW + 1)'(DEPTH);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cur <= '0;
      cur.in_rdy <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign s_ready_o = cur.in_rdy;
  assign m_valid_o = cur.out_valid;
  assign m_data_o = cur.out_data;

endmodule

// ============================================================================
// connection memories
module tcm_conn_mem
  import tcm_pkg::*;
#(
  parameter int WORDS = CM_WORDS,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [CM_WIDTH-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [CM_WIDTH-1:0] rdata_o,
  // per-channel lookup from the stream engine
  input wire logic lk_valid_i,
  input wire tcm_req_t lk_req_i,
  output logic lk_ready_o,
  // decoded channel commands
  output logic cmd_valid_o,
  output tcm_cmd_t cmd_o,
  input wire logic cmd_ready_i
);

  typedef struct packed {
    logic [15:0] control;
    logic illegal_seen;
    logic [15:0] rdata;
  } tcm_state_t;

  tcm_state_t cur;
  tcm_state_t next_cur;

  logic [CM_WIDTH-1:0] local_conn_mem [WORDS];
  logic [CM_WIDTH-1:0] backplane_conn_mem [WORDS];

  logic [2:0] mem_select;
  logic [IDX_W-1:0] idx;
  logic loc_we;
  logic bp_we;
  logic [CM_WIDTH-1:0] loc_rd_word;
  logic [CM_WIDTH-1:0] bp_rd_word;
  logic [CM_WIDTH-1:0] lk_word;
  tcm_cmd_t lk_cmd;
  logic fifo_ready;
  logic push;

  // ==========================================================================
  // decoding helpers
  function automatic logic mem_hit(input logic [ADDR_W-1:0] a, input logic [2:0] sel,
                                   input logic [2:0] want);
    mem_hit = a[ADDR_MEM_BIT] && (sel == want);
  endfunction

  function automatic tcm_cmd_t decode_word(input logic [CM_WIDTH-1:0] w,
                                           input tcm_rate_t rate,
                                           input tcm_port_t port,
                                           input logic [IDX_W-1:0] slot);
    tcm_cmd_t c;
    logic [8:0] lim;
    c = '0;
    lim = CHAN_MAX_32M;
    case (rate)
      RATE_2M: lim = CHAN_MAX_2M;
      RATE_4M: lim = CHAN_MAX_4M;
      RATE_8M: lim = CHAN_MAX_8M;
      RATE_16M: lim = CHAN_MAX_16M;
      default: lim = CHAN_MAX_32M;
    endcase
    c.port = port;
    c.slot = slot;
    c.src_local = w[CW_SRC_BIT];
    c.msg_mode = w[CW_MSG_BIT];
    if (c.msg_mode) begin
      // bits 12:8 are don't-care here
      c.msg = w[CW_CHAN_HI:0];
    end else begin
      c.hiz = w[CW_HIZ_BIT];
      if (rate == RATE_32M) begin
        c.stream = {1'b0, w[CW_STREAM_HI:CW_STREAM32_LO]};
        c.chan = w[CW_CHAN32_HI:0];
        // 32M exists on backplane streams only
        c.illegal = w[CW_SRC_BIT];
      end else begin
        c.stream = w[CW_STREAM_HI:CW_STREAM_LO];
        c.chan = {1'b0, w[CW_CHAN_HI:0]};
        c.illegal = c.chan > lim;
      end
    end
    decode_word = c;
  endfunction

  // ==========================================================================
  // memory access
  assign mem_select = cur.control[CTL_SEL_LO +: 3];
  assign idx = addr_i[IDX_W-1:0];
  assign loc_we = ce_i && wr_i && mem_hit(addr_i, mem_select, SEL_LOCAL);
  assign bp_we = ce_i && wr_i && mem_hit(addr_i, mem_select, SEL_BACKPLANE);
  assign loc_rd_word = local_conn_mem[idx];
  assign bp_rd_word = backplane_conn_mem[idx];

  // contents are left unreset: software initialises every word before use
  always_ff @(posedge clock_i) begin
    if (loc_we) begin
      local_conn_mem[idx] <= wdata_i;
    end
    if (bp_we) begin
      backplane_conn_mem[idx] <= wdata_i;
    end
  end

  // ==========================================================================
  // channel lookup into the command fifo
  assign lk_word = (lk_req_i.port == PORT_LOCAL) ? local_conn_mem[lk_req_i.slot]
                                                 : backplane_conn_mem[lk_req_i.slot];
  assign lk_cmd = decode_word(lk_word, lk_req_i.rate, lk_req_i.port, lk_req_i.slot);
  assign push = ce_i && lk_valid_i && fifo_ready;

  tcm_fifo #(
    .WIDTH($bits(tcm_cmd_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .s_valid_i(lk_valid_i),
    .s_data_i(lk_cmd),
    .s_ready_o(fifo_ready),
    .m_valid_o(cmd_valid_o),
    .m_data_o(cmd_o),
    .m_ready_i(cmd_ready_i)
  );

  // ==========================================================================
  // register file
  always_comb begin
    next_cur = cur;
    if (ce_i) begin
      next_cur.rdata = '0;
      if (push && lk_cmd.illegal) begin
        next_cur.illegal_seen = 1'b1;
      end else if (wr_i && !addr_i[ADDR_MEM_BIT] && addr_i[3:0] == REG_STATUS
                   && wdata_i[ST_ILLEGAL_BIT]) begin
        // a new illegal word outranks the clear
        next_cur.illegal_seen = 1'b0;
      end
      if (wr_i && !addr_i[ADDR_MEM_BIT] && addr_i[3:0] == REG_CONTROL) begin
        next_cur.control = wdata_i;
      end
      if (rd_i) begin
        if (mem_hit(addr_i, mem_select, SEL_LOCAL)) begin
          next_cur.rdata = loc_rd_word;
        end else if (mem_hit(addr_i, mem_select, SEL_BACKPLANE)) begin
          next_cur.rdata = bp_rd_word;
        end else if (!addr_i[ADDR_MEM_BIT]) begin
          case (addr_i[3:0])
            REG_CONTROL: next_cur.rdata = cur.control;
            REG_STATUS: begin
              next_cur.rdata[ST_ILLEGAL_BIT] = cur.illegal_seen;
              next_cur.rdata[ST_READY_BIT] = fifo_ready;
            end
            default: next_cur.rdata = '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cur <= '0;
      cur.control <= CONTROL_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign rdata_o = cur.rdata;
  assign lk_ready_o = fifo_ready;

  // ==========================================================================
  // assertions
  property p_local_write;
    @(posedge clock_i) disable iff (!rst_b_i)
      loc_we |=> local_conn_mem[$past(idx)] == $past(wdata_i);
  endproperty
  a_local_write: assert property (p_local_write) else $error("local word not stored");

  property p_bp_write;
    @(posedge clock_i) disable iff (!rst_b_i)
      bp_we |=> backplane_conn_mem[$past(idx)] == $past(wdata_i);
  endproperty
  a_bp_write: assert property (p_bp_write) else $error("backplane word not stored");

  property p_read_back;
    @(posedge clock_i) disable iff (!rst_b_i)
      ce_i && rd_i && mem_hit(addr_i, mem_select, SEL_BACKPLANE)
      |=> rdata_o == $past(bp_rd_word) ##1 (rdata_o == '0 || $past(rd_i) || !$past(ce_i));
  endproperty
  a_read_back: assert property (p_read_back) else $error("backplane read wrong");

  property p_src_port;
    @(posedge clock_i) disable iff (!rst_b_i)
      push |-> lk_cmd.src_local == lk_word[CW_SRC_BIT] && lk_cmd.port == lk_req_i.port;
  endproperty
  a_src_port: assert property (p_src_port) else $error("source port wrong");

  property p_message;
    @(posedge clock_i) disable iff (!rst_b_i)
      push && lk_word[CW_MSG_BIT]
      |-> lk_cmd.msg_mode && lk_cmd.msg == lk_word[7:0] && !lk_cmd.hiz && lk_cmd.stream == '0;
  endproperty
  a_message: assert property (p_message) else $error("message decode wrong");

  property p_connect;
    @(posedge clock_i) disable iff (!rst_b_i)
      push && !lk_word[CW_MSG_BIT] && lk_req_i.rate != RATE_32M
      |-> lk_cmd.stream == lk_word[12:8] && lk_cmd.chan == {1'b0, lk_word[7:0]};
  endproperty
  a_connect: assert property (p_connect) else $error("connection decode wrong");

  property p_limit;
    @(posedge clock_i) disable iff (!rst_b_i)
      push && !lk_word[CW_MSG_BIT] && lk_req_i.rate == RATE_2M && lk_word[7:5] != 3'h0
      |-> lk_cmd.illegal;
  endproperty
  a_limit: assert property (p_limit) else $error("channel over 31 not flagged");

  property p_fast;
    @(posedge clock_i) disable iff (!rst_b_i)
      push && !lk_word[CW_MSG_BIT] && lk_req_i.rate == RATE_32M
      |-> lk_cmd.chan == lk_word[8:0] && lk_cmd.stream == {1'b0, lk_word[12:9]};
  endproperty
  a_fast: assert property (p_fast) else $error("32M decode wrong");

  property p_hiz;
    @(posedge clock_i) disable iff (!rst_b_i)
      push && !lk_word[CW_MSG_BIT] |-> lk_cmd.hiz == lk_word[CW_HIZ_BIT];
  endproperty
  a_hiz: assert property (p_hiz) else $error("tristate bit wrong");

  property p_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_o);
  endproperty
  a_hold: assert property (p_hold) else $error("command dropped under stall");

  property p_sticky;
    @(posedge clock_i) disable iff (!rst_b_i)
      push && lk_cmd.illegal |=> cur.illegal_seen ##1 (cur.illegal_seen || $past(ce_i && wr_i));
  endproperty
  a_sticky: assert property (p_sticky) else $error("illegal flag lost");

  c_local_write: cover property (@(posedge clock_i) disable iff (!rst_b_i) loc_we);
  c_bp_read: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    ce_i && rd_i && mem_hit(addr_i, mem_select, SEL_BACKPLANE));
  c_fifo_full: cover property (@(posedge clock_i) disable iff (!rst_b_i) !lk_ready_o);
  c_message: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    push && lk_cmd.msg_mode);

endmodule

`default_nettype wire

// ===== dv/tcm_drain_model.sv
`timescale 1ns/10ps
`default_nettype none

// ============================================================================
// command consumer on the far side: prompt, slow (every other cycle) or stalled
module tcm_drain_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  // pacing
  input wire logic stall_i,
  input wire logic slow_i,
  // handshake
  output logic cmd_ready_o
);
  logic phase;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  assign cmd_ready_o = ~stall_i & (~slow_i | phase);
endmodule

`default_nettype wire

// ===== dv/tcm_conn_mem_test.sv
`timescale 1ns/10ps
`default_nettype none

module tcm_conn_mem_test;
  import tcm_pkg::*;

  typedef struct packed {
    tcm_port_t port;
    logic [15:0] word;
    tcm_rate_t rate;
    logic ill;
  } tcm_tb_row_t;

  // ==========================================================================
  // signals
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic lk_valid_i = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [CM_WIDTH-1:0] wdata_i = '0;
  logic [CM_WIDTH-1:0] rdata_o;
  tcm_req_t lk_req_i = '0;
  logic lk_ready_o;
  logic cmd_valid_o;
  logic cmd_ready;
  tcm_cmd_t cmd_o;
  tcm_cmd_t got_q[$];
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;

  tcm_tb_row_t rows[9] = '{
    '{PORT_LOCAL, 16'h801F, RATE_2M, 1'b0},
    '{PORT_BACKPLANE, 16'h0020, RATE_2M, 1'b1},
    '{PORT_LOCAL, 16'h1F3F, RATE_4M, 1'b0},
    '{PORT_BACKPLANE, 16'h8280, RATE_8M, 1'b1},
    '{PORT_LOCAL, 16'h20FF, RATE_16M, 1'b0},
    '{PORT_BACKPLANE, 16'h1FFF, RATE_32M, 1'b0},
    '{PORT_LOCAL, 16'h9E00, RATE_32M, 1'b1},
    '{PORT_LOCAL, 16'h7FA5, RATE_2M, 1'b0},
    '{PORT_BACKPLANE, 16'hC05A, RATE_16M, 1'b0}
  };

  tcm_conn_mem i_dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .lk_valid_i(lk_valid_i), .lk_req_i(lk_req_i), .lk_ready_o(lk_ready_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_ready_i(cmd_ready)
  );

  tcm_drain_model i_drain (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .stall_i(stall), .slow_i(slow),
    .cmd_ready_o(cmd_ready)
  );

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (rst_b_i && cmd_valid_o === 1'b1 && cmd_ready === 1'b1) begin
      got_q.push_back(cmd_o);
    end
  end

  // a run of this length needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  // ==========================================================================
  // tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string name, logic [39:0] got, logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bus tasks are entered and left just after a rising edge
  task automatic wr(logic [14:0] a, logic [15:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    // one idle edge so that back-to-back calls never drive the strobe twice at once
    @(posedge clock_i);
  endtask

  task automatic rd(logic [14:0] a, logic [15:0] exp);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    chk("rdata", rdata_o, exp);
    @(posedge clock_i);
  endtask

  task automatic lookup(tcm_port_t p, logic [12:0] s, tcm_rate_t r);
    lk_valid_i <= 1'b1;
    lk_req_i <= '{port: p, slot: s, rate: r};
    do @(posedge clock_i); while (lk_ready_o !== 1'b1);
    lk_valid_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wait_cmds(int n);
    while (got_q.size() < n) @(posedge clock_i);
  endtask

  function automatic logic [14:0] maddr(logic [12:0] s);
    return {2'b10, s};
  endfunction

  // expected command and the mask of fields that the mode defines
  function automatic tcm_cmd_t exp_cmd(tcm_port_t p, logic [12:0] s, logic [15:0] w,
                                       tcm_rate_t r, output tcm_cmd_t m);
    tcm_cmd_t c;
    logic [8:0] lim;
    c = '0;
    m = '1;
    c.port = p;
    c.slot = s;
    c.msg_mode = w[14];
    c.src_local = w[15];
    if (w[14]) begin
      c.msg = w[7:0];
      m.src_local = 1'b0;
      m.illegal = 1'b0;
    end else begin
      m.msg = '0;
      c.hiz = w[13];
      if (r == RATE_32M) begin
        c.stream = {1'b0, w[12:9]};
        c.chan = w[8:0];
        c.illegal = w[15];
      end else begin
        case (r)
          RATE_2M: lim = CHAN_MAX_2M;
          RATE_4M: lim = CHAN_MAX_4M;
          RATE_8M: lim = CHAN_MAX_8M;
          default: lim = CHAN_MAX_16M;
        endcase
        c.stream = w[12:8];
        c.chan = {1'b0, w[7:0]};
        c.illegal = ({1'b0, w[7:0]} > lim);
      end
    end
    return c;
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    tcm_tb_row_t r;
    logic [12:0] s;
    tcm_cmd_t c;
    tcm_cmd_t e;
    tcm_cmd_t m;
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(negedge clock_i);
    chk("rdata_rst", rdata_o, 16'h0000);
    chk("lk_ready_rst", lk_ready_o, 1'b1);
    chk("cmd_valid_rst", cmd_valid_o, 1'b0);
    @(posedge clock_i);
    rd(15'h0000, CONTROL_RESET);
    rd(15'h0001, 16'h0002);
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      s = 13'h1FFF - 13'(i);
      wr(15'h0000, (r.port == PORT_LOCAL) ? {13'h0, SEL_LOCAL} : {13'h0, SEL_BACKPLANE});
      wr(maddr(s), r.word);
      rd(maddr(s), r.word);
      lookup(r.port, s, r.rate);
      wait_cmds(1);
      c = got_q.pop_front();
      e = exp_cmd(r.port, s, r.word, r.rate, m);
      chk("cmd", c & m, e & m);
      rd(15'h0001, {14'h0, 1'b1, r.ill});
      if (r.ill) begin
        wr(15'h0001, 16'h0001);
      end
    end
    // ------------------------------------------------------------------------
    // the two memories are separate, and a reserved selection reaches neither
    wr(15'h0000, {13'h0, SEL_LOCAL});
    wr(maddr(13'h0000), 16'h1234);
    wr(15'h0000, {13'h0, SEL_BACKPLANE});
    wr(maddr(13'h0000), 16'h5678);
    rd(maddr(13'h0000), 16'h5678);
    wr(15'h0000, 16'h0002);
    wr(maddr(13'h0000), 16'hFFFF);
    rd(maddr(13'h0000), 16'h0000);
    rd(15'h0005, 16'h0000);
    wr(15'h0000, {13'h0, SEL_LOCAL});
    rd(maddr(13'h0000), 16'h1234);
    // ------------------------------------------------------------------------
    // fill the queue with the far side stalled, then drain it slowly
    for (int k = 0; k < 10; k++) begin
      wr(maddr(13'(k)), 16'h0001);
    end
    stall <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      lookup(PORT_LOCAL, 13'(k), RATE_2M);
    end
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    chk("lk_ready_full", lk_ready_o, 1'b0);
    @(posedge clock_i);
    stall <= 1'b0;
    slow <= 1'b1;
    lookup(PORT_LOCAL, 13'h0009, RATE_2M);
    wait_cmds(10);
    for (int k = 0; k < 10; k++) begin
      c = got_q.pop_front();
      chk("fifo_order", c.slot, 13'(k));
    end
    // ------------------------------------------------------------------------
    // clock enable low freezes the register file
    ce_i <= 1'b0;
    wr(15'h0000, {13'h0, SEL_BACKPLANE});
    ce_i <= 1'b1;
    rd(15'h0000, {13'h0, SEL_LOCAL});
    // ------------------------------------------------------------------------
    // reset in mid-run: registers return to reset, memory contents stay
    wr(15'h0000, {13'h0, SEL_BACKPLANE});
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(negedge clock_i);
    chk("cmd_valid_rst2", cmd_valid_o, 1'b0);
    chk("lk_ready_rst2", lk_ready_o, 1'b1);
    @(posedge clock_i);
    rd(15'h0000, CONTROL_RESET);
    rd(maddr(13'h0000), 16'h0001);
    complete_run();
  end
endmodule

`default_nettype wire
